//--- dea_map.vh
// Purpose: constants for the data nonvolatile access sequencer
// Assumes: byte-wide special function register bus of the core
// Notes:   definitions only
`ifndef DEA_MAP_VH
`define DEA_MAP_VH
// ****************************************
// register addresses
// ****************************************
`define DEA_CTRL_ADDR     8'h40
`define DEA_CTRL_BANK     8'h01
`define DEA_ADDR_ADDR     8'h20
`define DEA_DATA_ADDR     8'h21
// ****************************************
// control bit positions and register reset values
// ****************************************
`define DEA_BIT_RD        0
`define DEA_BIT_RD_ENABLE 1
`define DEA_BIT_WR        2
`define DEA_BIT_WR_ENABLE 3
`define DEA_CTRL_RST      4'h0
`define DEA_ADDR_RST      5'h00
`define DEA_DATA_RST      8'h00
// ****************************************
// timing
// ****************************************
`define DEA_CLK_HZ        20000000
`define DEA_RD_CYC        8'h04
`define DEA_WR_NS         2000000
`define DEA_WR_CYC        ((`DEA_WR_NS / 1000) * (`DEA_CLK_HZ / 1000000))
`endif

//--- dea_seq.v
// Purpose: byte read/write sequencer for the 32 x 8 data nonvolatile memory
// Assumes: core bus: sfr_addr/sfr_wr, bank_pointer, indirect via pointer
// Notes:   array model stands in for the cell array; write time is a parameter
//          control writes while busy are dropped, never queued
//
// Operation
// - sleep during access fails the access
// - no address auto-increment on reads
// - control reachable only when bank is one
// - control at 040H, bank 01H, indirect access
// - read start needs read enable set
// - read start launches read at address
// - write start ignored without write enable
// - hardware clears write start when done
// - write end sets done flag, cleared serviced
// - five address bits, upper three read zero
`timescale 1ns/1ns
`include "dea_map.vh"
module dea_seq #(
    parameter WR_CYC = `DEA_WR_CYC
) (
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_indirect,
    input  wire [7:0] bank_pointer,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    input  wire       low_power_req,
    input  wire       irq_serviced,
    output reg  [7:0] sfr_rdata,
    output reg        nv_write_done_flag,
    output reg        nv_busy
);
    // ****************************************
    // state and storage
    // ****************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_RD   = 2'd1;
    localparam ST_WR   = 2'd2;

    reg [1:0]  st_q;
    reg [1:0]  st_d;
    reg [4:0]  nv_address_reg_q;
    reg [4:0]  nv_address_reg_d;
    reg [7:0]  nv_data_reg_q;
    reg [7:0]  nv_data_reg_d;
    reg [3:0]  nv_control_q;
    reg [3:0]  nv_control_d;
    reg [31:0] cnt_q;
    reg [31:0] cnt_d;
    reg        done_d;
    reg        busy_d;
    reg [7:0]  cells [0:31];
    reg [7:0]  rdata_d;

    // unrestricted decode would let bank 0 reach control
    wire ctrl_hit = sfr_indirect && (sfr_addr == `DEA_CTRL_ADDR)
                    && (bank_pointer == `DEA_CTRL_BANK);
    wire addr_hit = !sfr_indirect && (sfr_addr == `DEA_ADDR_ADDR);
    wire data_hit = !sfr_indirect && (sfr_addr == `DEA_DATA_ADDR);
    wire [3:0] cw = sfr_wdata[3:0];

    // ****************************************
    // launch and end events
    // ****************************************
    // a write counts WR_CYC edges from its launch edge
    localparam [31:0] WR_LAST = WR_CYC - 1;
    localparam [31:0] RD_LAST = {24'h0, `DEA_RD_CYC};

    wire       idle_w   = (st_q == ST_IDLE);
    // busy drops control writes; keeps the sequencer single-issue
    wire       ctrl_wr  = sfr_wr && ctrl_hit && idle_w;
    // enable must already be set
    wire       wr_go    = ctrl_wr && cw[`DEA_BIT_WR] && nv_control_q[`DEA_BIT_WR_ENABLE];
    wire       rd_go    = ctrl_wr && cw[`DEA_BIT_RD] && nv_control_q[`DEA_BIT_RD_ENABLE]
                          && !wr_go;
    wire       abort_w  = !idle_w && low_power_req;
    wire       rd_end   = (st_q == ST_RD) && !low_power_req && (cnt_q == RD_LAST);
    wire       wr_end   = (st_q == ST_WR) && !low_power_req && (cnt_q == WR_LAST);
    wire [7:0] cell_rd  = cells[nv_address_reg_q];

    // ****************************************
    // register reads
    // ****************************************
    always @* begin
        rdata_d = 8'h00;
        if (ctrl_hit) begin
            rdata_d = {4'h0, nv_control_q};
        end else if (addr_hit) begin
            rdata_d = {3'h0, nv_address_reg_q};
        end else if (data_hit) begin
            rdata_d = nv_data_reg_q;
        end
    end

    // ****************************************
    // sequencer next state
    // ****************************************
    always @* begin
        st_d         = st_q;
        nv_control_d = nv_control_q;
        cnt_d        = cnt_q;
        busy_d       = nv_busy;
        case (st_q)
            ST_IDLE: begin
                if (ctrl_wr) begin
                    nv_control_d[`DEA_BIT_WR_ENABLE] = cw[`DEA_BIT_WR_ENABLE];
                    nv_control_d[`DEA_BIT_RD_ENABLE] = cw[`DEA_BIT_RD_ENABLE];
                    cnt_d = 32'h0;
                end
                if (wr_go) begin
                    nv_control_d[`DEA_BIT_WR] = 1'b1;
                    busy_d = 1'b1;
                    st_d = ST_WR;
                end else if (rd_go) begin
                    nv_control_d[`DEA_BIT_RD] = 1'b1;
                    busy_d = 1'b1;
                    st_d = ST_RD;
                end
            end
            ST_RD: begin
                cnt_d = cnt_q + 32'h1;
                // address not advanced after a read
                if (abort_w || rd_end) begin
                    nv_control_d[`DEA_BIT_RD] = 1'b0;
                    busy_d = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            ST_WR: begin
                cnt_d = cnt_q + 32'h1;
                if (abort_w || wr_end) begin
                    nv_control_d[`DEA_BIT_WR] = 1'b0;
                    busy_d = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // data, address and done flag
    // ****************************************
    always @* begin
        nv_address_reg_d = nv_address_reg_q;
        if (sfr_wr && addr_hit) begin
            nv_address_reg_d = sfr_wdata[4:0];
        end
    end

    always @* begin
        nv_data_reg_d = nv_data_reg_q;
        if (sfr_wr && data_hit) begin
            nv_data_reg_d = sfr_wdata;
        end
        if (abort_w && (st_q == ST_RD)) begin
            // aborted read leaves data invalid
            nv_data_reg_d = 8'h00;
        end else if (rd_end) begin
            nv_data_reg_d = cell_rd;
        end
    end

    // set beats service clear in the same cycle
    always @* begin
        done_d = nv_write_done_flag;
        if (irq_serviced) begin
            done_d = 1'b0;
        end
        if (wr_end) begin
            done_d = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            nv_control_q <= `DEA_CTRL_RST;
            cnt_q <= 32'h0;
            nv_busy <= 1'b0;
        end else begin
            st_q <= st_d;
            nv_control_q <= nv_control_d;
            cnt_q <= cnt_d;
            nv_busy <= busy_d;
        end
    end

    // software-visible registers, one cycle read latency
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_address_reg_q <= `DEA_ADDR_RST;
            nv_data_reg_q <= `DEA_DATA_RST;
            nv_write_done_flag <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            nv_address_reg_q <= nv_address_reg_d;
            nv_data_reg_q <= nv_data_reg_d;
            nv_write_done_flag <= done_d;
            sfr_rdata <= rdata_d;
        end
    end

    // cell array has no reset, like the real memory
    // cell untouched on abort, no done flag
    always @(posedge clk) begin
        if (wr_end) begin
            cells[nv_address_reg_q] <= nv_data_reg_q;
        end
    end
endmodule

//--- dea_seq_asserts.sv
// Purpose: port checker for the nonvolatile access sequencer
// Assumes: small WR_CYC in simulation
// Notes:   enable bits shadowed from control writes
`timescale 1ns/1ns
module dea_seq_chk #(parameter WR_CYC = 10) (
    input wire       clk,
    input wire       rst_b,
    input wire [7:0] sfr_addr,
    input wire       sfr_indirect,
    input wire [7:0] bank_pointer,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire       low_power_req,
    input wire       irq_serviced,
    input wire [7:0] sfr_rdata,
    input wire       nv_write_done_flag,
    input wire       nv_busy
);
// ****
// properties
// ****
reg  [1:0] en_q;
wire       ctl = sfr_indirect && bank_pointer == 8'h01 && sfr_addr == 8'h40;
wire       cw  = ctl && sfr_wr && !nv_busy;
always @(posedge clk or negedge rst_b)
    if (!rst_b) en_q <= 2'h0;
    else if (cw) en_q <= {sfr_wdata[3], sfr_wdata[1]};
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
property p_bank; sfr_indirect && bank_pointer != 8'h01 && sfr_addr == 8'h40
    |=> sfr_rdata == 8'h00; endproperty
a_bank: assert property (p_bank) else $error("control seen off bank one");
property p_hi; ctl |=> sfr_rdata[7:4] == 4'h0; endproperty
a_hi: assert property (p_hi) else $error("control upper bits set");
property p_adr; !sfr_indirect && sfr_addr == 8'h20 |=> sfr_rdata[7:5] == 3'h0; endproperty
a_adr: assert property (p_adr) else $error("address upper bits set");
property p_ref; cw && en_q == 2'h0 |=> !nv_busy; endproperty
a_ref: assert property (p_ref) else $error("start taken without enable");
property p_rd; disable iff (!rst_b || low_power_req)
    cw && en_q[0] && sfr_wdata[2:0] == 3'h3 |=> nv_busy[*5] ##1 !nv_busy; endproperty
a_rd: assert property (p_rd) else $error("read cycle length wrong");
property p_wr; cw && en_q[1] && sfr_wdata[3:2] == 2'h3 |=> nv_busy ##[1:1000] $fell(nv_busy);
endproperty
a_wr: assert property (p_wr) else $error("write never ends");
property p_done; $rose(nv_write_done_flag) |-> $fell(nv_busy); endproperty
a_done: assert property (p_done) else $error("flag without write end");
property p_hold; nv_write_done_flag && !irq_serviced |=> nv_write_done_flag; endproperty
a_hold: assert property (p_hold) else $error("flag dropped early");
property p_slp; low_power_req && nv_busy |=> !nv_busy && !$rose(nv_write_done_flag); endproperty
a_slp: assert property (p_slp) else $error("access survives low power");
c_wr: cover property (cw && sfr_wdata[3:2] == 2'h3);
c_done: cover property ($rose(nv_write_done_flag));
c_slp: cover property (low_power_req && nv_busy);
c_rd: cover property (cw && en_q[0] && sfr_wdata[2:0] == 3'h3);
endmodule
bind dea_seq dea_seq_chk #(.WR_CYC(WR_CYC)) u_chk (.*);

//--- testbench.sv
// Purpose: random and corner tests of the access sequencer
// Assumes: WR_CYC of 10
// Notes:   inputs change at falling edge
`timescale 1ns/1ns
module testbench;
// ****
// bench
// ****
reg         clk, rst_b, sfr_indirect, sfr_wr, low_power_req, irq_serviced;
reg  [7:0]  sfr_addr, bank_pointer, sfr_wdata, v, a, d;
wire [7:0]  sfr_rdata;
wire        done, busy;
reg  [31:0] seed;
integer     mismatches, n_compared, i, k;
dea_seq #(.WR_CYC(10)) u_dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_indirect(sfr_indirect), .bank_pointer(bank_pointer), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .low_power_req(low_power_req), .irq_serviced(irq_serviced),
    .sfr_rdata(sfr_rdata), .nv_write_done_flag(done), .nv_busy(busy));
function [31:0] xs(input [31:0] x); reg [31:0] y; begin
    y = x ^ (x << 13); y = y ^ (y >> 17); xs = y ^ (y << 5); end endfunction
function [7:0] ea(input [7:0] x); ea = {3'h0, x[4:0]}; endfunction
task print_verdict; begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish; end endtask
task chk(input [47:0] n, input [7:0] s, input [7:0] e); begin
    n_compared = n_compared + 1;
    if (s !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch %0s exp %h seen %h", n, e, s); end end endtask
// held high across back-to-back writes
task sw(input [7:0] ad, input i1, input [7:0] dt); begin @(negedge clk);
    sfr_addr = ad; sfr_indirect = i1; bank_pointer = {7'h0, i1}; sfr_wdata = dt;
    sfr_wr = 1'b1; end endtask
task rd(input [7:0] ad, input i1, input [7:0] bk); begin @(negedge clk);
    sfr_wr = 1'b0; sfr_addr = ad; sfr_indirect = i1; bank_pointer = bk;
    @(negedge clk); v = sfr_rdata; end endtask
task poll(input integer b); begin k = 0; rd(8'h40, 1, 8'h01);
    while (v[b] !== 1'b0 && k < 40) begin rd(8'h40, 1, 8'h01); k = k + 1; end
    if (k == 40) begin mismatches = mismatches + 1; print_verdict; end end endtask
initial begin clk = 0; forever #25 clk = ~clk; end
initial begin
    {rst_b, sfr_indirect, sfr_wr, low_power_req, irq_serviced} = 5'h0;
    {sfr_addr, bank_pointer, sfr_wdata} = 24'h0;
    mismatches = 0; n_compared = 0; seed = 34;
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    rd(8'h40, 1, 8'h01); chk("ctlrst", v, 8'h00);
    sw(8'h40, 1, 8'h08); rd(8'h40, 1, 8'h00); chk("bank0", v, 8'h00);
    rd(8'h40, 1, 8'h01); chk("bank1", v, 8'h08);
    sw(8'h40, 1, 8'h00); sw(8'h40, 1, 8'h04); rd(8'h40, 1, 8'h01);
    chk("wroff", v, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
        seed = xs(seed); a = (i == 0) ? 8'hff : seed[7:0]; d = seed[15:8];
        sw(8'h20, 0, a); rd(8'h20, 0, 8'h00); chk("addr", v, ea(a));
        sw(8'h21, 0, d); sw(8'h40, 1, 8'h08); sw(8'h40, 1, 8'h0c);
        if (i == 1) begin
            // service pulse on the write-end edge: set must win
            @(negedge clk) sfr_wr = 1'b0;
            repeat (9) @(negedge clk);
            irq_serviced = 1'b1;
            @(negedge clk) irq_serviced = 1'b0;
        end
        poll(2);
        chk("done", {7'h0, done}, 8'h01);
        @(negedge clk) irq_serviced = 1'b1;
        @(negedge clk) irq_serviced = 1'b0;
        chk("clr", {7'h0, done}, 8'h00);
        sw(8'h21, 0, ~d); sw(8'h40, 1, 8'h02); sw(8'h40, 1, 8'h03); poll(0);
        rd(8'h21, 0, 8'h00); chk("data", v, d);
        sw(8'h40, 1, 8'h00); end
    sw(8'h40, 1, 8'h08); sw(8'h40, 1, 8'h0c);
    @(negedge clk) begin sfr_wr = 1'b0; low_power_req = 1'b1; end
    @(negedge clk) low_power_req = 1'b0;
    rd(8'h40, 1, 8'h01); chk("abort", v, 8'h08);
    chk("aflag", {6'h0, done, busy}, 8'h00);
    sw(8'h21, 0, 8'ha5); sw(8'h40, 1, 8'h02); sw(8'h40, 1, 8'h03);
    @(negedge clk) begin sfr_wr = 1'b0; low_power_req = 1'b1; end
    @(negedge clk) low_power_req = 1'b0;
    rd(8'h40, 1, 8'h01); chk("rctl", v, 8'h02);
    rd(8'h21, 0, 8'h00); chk("rabort", v, 8'h00);
    print_verdict;
end
endmodule
